/* common/fhc_pkg.sv */
// constants and types shared by the host command interpreter
package fhc_pkg;
    localparam int DRV_CNT   = 4;
    localparam int PTR_CNT   = 16;
    localparam int STR_MIN   = 4;
    localparam int STR_MAX   = 9;
    // byte command numbers (upper nibble)
    localparam logic [3:0] BC_EXEC   = 4'h0;
    localparam logic [3:0] BC_LOADP  = 4'h1;
    localparam logic [3:0] BC_RESTOR = 4'h2;
    localparam logic [3:0] BC_WPSET  = 4'h3;
    localparam logic [3:0] BC_WPCLR  = 4'h4;
    // pointer defaults
    localparam logic [15:0] PTR0_DFLT = 16'h0080;
    localparam logic [11:0] PTRN_LOW  = 12'h000;
    // command string layout
    localparam logic [3:0]  IDX_CMD  = 4'h0;
    localparam logic [3:0]  IDX_STAT = 4'h1;
    localparam logic [7:0]  STAT_OK  = 8'h01;
    localparam logic [7:0]  STAT_FAIL_BIT = 8'h80;
    localparam logic [7:0]  STAT_ERR_NZ   = 8'hC1;
    localparam logic [7:0]  STAT_ERR_NODRV = 8'hC2;
    localparam logic [7:0]  STAT_ERR_MULTI = 8'hC3;
    localparam logic [7:0]  STAT_ERR_CMD   = 8'hC4;
    // boot
    localparam logic [3:0]  BOOT_DRV_MASK = 4'h1;
    localparam logic [15:0] BOOT_DEST     = 16'h0000;
    localparam logic [15:0] BOOT_LAST     = 16'h007F;
    // boot borrows the sector read string command
    localparam logic [3:0]  BOOT_CMD      = 4'h2;

    typedef enum logic [3:0] {
        FHC_IDLE  = 4'b0000,
        FHC_ADRLO = 4'b0001,
        FHC_ADRHI = 4'b0010,
        FHC_FETCH = 4'b0011,
        FHC_FWAIT = 4'b0100,
        FHC_OPER  = 4'b0101,
        FHC_OWAIT = 4'b0110,
        FHC_STAT  = 4'b0111,
        FHC_SWAIT = 4'b1000,
        FHC_BOOT  = 4'b1001,
        FHC_BWAIT = 4'b1010
    } fhc_state_e;

    // bytes a string command needs; 0 means illegal command
    function automatic logic [3:0] fhc_str_len(input logic [3:0] cmd);
        case (cmd)
            4'h0: fhc_str_len = 4'h7;
            4'h1, 4'h2: fhc_str_len = 4'h7;
            4'h3: fhc_str_len = 4'h4;
            4'h4, 4'h5: fhc_str_len = 4'h5;
            4'h9: fhc_str_len = 4'h6;
            4'h7, 4'h8: fhc_str_len = 4'h9;
            4'hA, 4'hB: fhc_str_len = 4'h7;
            default: fhc_str_len = 4'h0;
        endcase
    endfunction : fhc_str_len
endpackage : fhc_pkg

/* design/fhc_interpreter.sv */
// single-port byte command interpreter with string fetch over dma
// ============================================================
// Behaviour
// - upper nibble command, lower nibble index/mask
// - command 0 executes string at pointer
// - command 1 loads pointer, low then high
// - command 2 restores selected drives
// - command 3 sets selected write protects
// - power-on clears all write protects
// - command 4 clears selected write protects
// - commands 5-15 only clear interrupt
// - reset loads pointer defaults
// - mask bit n selects drive n
// - empty drive mask starts no drive op; a string reports C2
// - fetch exactly bytes a legal command needs; an error stops after byte 1
// - command 0 fetches string then executes
// - boot reads drive 0 sector into 0-7F
// - boot error shown, boot retried
// - status zero at start; nonzero at end
// - string byte 0: command and one-hot mask
`timescale 1ns/1ns
module fhc_interpreter
    import fhc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        port_wr,
    input  wire logic [7:0]  port_data,
    input  wire logic        boot_req,
    input  wire logic        intr_mode,
    output logic             intr_pend,
    output logic             mem_req,
    output logic             mem_we,
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [7:0]  mem_rdata,
    output logic             drv_op_go,
    output logic [3:0]       drv_op_cmd,
    output logic [3:0]       drv_op_mask,
    output logic [15:0]      drv_op_buf,
    input  wire logic        drv_op_done,
    input  wire logic [7:0]  drv_op_stat,
    output logic [3:0]       restore_req,
    output logic [3:0]       wr_protect,
    output logic [7:0]       error_code_indicator
);
    // ========================================================
    // state
    fhc_state_e       st_reg, st_next;
    logic [15:0]      ptr_reg [PTR_CNT];
    logic [3:0]       idx_reg;
    logic [7:0]       lo_reg;
    logic [15:0]      base_reg;
    logic [3:0]       cnt_reg;
    logic [3:0]       len_reg;
    logic [7:0]       sbuf_reg [STR_MAX];
    logic [7:0]       stat_reg;
    logic             boot_reg;
    logic [3:0]       restore_reg;
    logic [3:0]       wp_reg;
    logic [7:0]       err_reg;
    logic             intr_reg;
    logic             go_reg;

    // ========================================================
    // decode
    wire [3:0] bc_num  = port_data[7:4];
    wire [3:0] bc_low  = port_data[3:0];
    wire       take    = port_wr && st_reg == FHC_IDLE;
    wire       is_exec = take && bc_num == BC_EXEC;
    wire       is_load = take && bc_num == BC_LOADP;
    wire       is_rest = take && bc_num == BC_RESTOR;
    wire       is_wps  = take && bc_num == BC_WPSET;
    wire       is_wpc  = take && bc_num == BC_WPCLR;
    wire       is_nop  = take && bc_num > BC_WPCLR;
    wire [3:0] s_cmd   = sbuf_reg[IDX_CMD][7:4];
    wire [3:0] s_mask  = sbuf_reg[IDX_CMD][3:0];
    wire [3:0] s_len   = fhc_str_len(s_cmd);
    wire       one_hot = s_mask != 4'h0 && (s_mask & (s_mask - 4'h1)) == 4'h0;
    // status judged as it arrives: the buffer copy lands a cycle late
    wire [7:0] chk_err = mem_rdata != 8'h00          ? STAT_ERR_NZ
                       : s_mask == 4'h0              ? STAT_ERR_NODRV
                       : !one_hot                    ? STAT_ERR_MULTI
                       : s_len == 4'h0               ? STAT_ERR_CMD
                       : 8'h00;

    assign mem_req   = st_reg == FHC_FWAIT || st_reg == FHC_SWAIT;
    assign mem_we    = st_reg == FHC_SWAIT;
    assign mem_addr  = st_reg == FHC_SWAIT ? base_reg + {12'h000, IDX_STAT}
                     : base_reg + {12'h000, cnt_reg};
    assign mem_wdata = stat_reg;

    // ========================================================
    // sequencer
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            FHC_IDLE: begin
                if (boot_reg) st_next = FHC_BOOT;
                else if (is_load) st_next = FHC_ADRLO;
                else if (is_exec) st_next = FHC_FETCH;
            end
            FHC_ADRLO: if (port_wr) st_next = FHC_ADRHI;
            FHC_ADRHI: if (port_wr) st_next = FHC_IDLE;
            FHC_FETCH: st_next = FHC_FWAIT;
            FHC_FWAIT: begin
                if (mem_ack) begin
                    if (cnt_reg == IDX_STAT && chk_err != 8'h00)
                        st_next = FHC_STAT;
                    else if (cnt_reg + 4'h1 < ((cnt_reg == IDX_STAT)
                                ? s_len : len_reg))
                        st_next = FHC_FETCH;
                    else
                        st_next = FHC_OPER;
                end
            end
            FHC_OPER:  st_next = FHC_OWAIT;
            FHC_OWAIT: if (drv_op_done) st_next = FHC_STAT;
            FHC_STAT:  st_next = FHC_SWAIT;
            FHC_SWAIT: if (mem_ack) st_next = FHC_IDLE;
            FHC_BOOT:  st_next = FHC_BWAIT;
            FHC_BWAIT: begin
                if (drv_op_done)
                    st_next = (drv_op_stat == STAT_OK) ? FHC_IDLE
                                                       : FHC_BOOT;
            end
            default:   st_next = FHC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) st_reg <= FHC_IDLE;
        else st_reg <= st_next;
    end

    // ========================================================
    // pointers, only touched by load or reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ptr_reg[0] <= PTR0_DFLT;
            for (int i = 1; i < PTR_CNT; i++)
                ptr_reg[i] <= {4'(i), PTRN_LOW};
        end else if (st_reg == FHC_ADRHI && port_wr) begin
            ptr_reg[idx_reg] <= {port_data, lo_reg};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            idx_reg <= 4'h0;
            lo_reg  <= 8'h00;
        end else begin
            if (take) idx_reg <= bc_low;
            if (st_reg == FHC_ADRLO && port_wr) lo_reg <= port_data;
        end
    end

    // ========================================================
    // string fetch and status
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            base_reg <= 16'h0000;
            cnt_reg  <= 4'h0;
            len_reg  <= 4'h2;
            stat_reg <= 8'h00;
            go_reg   <= 1'b0;
            for (int i = 0; i < STR_MAX; i++) sbuf_reg[i] <= 8'h00;
        end else begin
            go_reg <= st_reg == FHC_OPER || st_reg == FHC_BOOT;
            if (is_exec && !boot_reg) begin
                base_reg <= ptr_reg[bc_low];
                cnt_reg  <= 4'h0;
                len_reg  <= 4'h2;
            end
            if (st_reg == FHC_FWAIT && mem_ack) begin
                sbuf_reg[cnt_reg] <= mem_rdata;
                cnt_reg <= cnt_reg + 4'h1;
                if (cnt_reg == IDX_STAT) len_reg <= s_len;
                if (cnt_reg == IDX_STAT && chk_err != 8'h00)
                    stat_reg <= chk_err;
            end
            if (st_reg == FHC_OWAIT && drv_op_done)
                stat_reg <= (drv_op_stat == 8'h00) ? STAT_OK
                          : (drv_op_stat | STAT_FAIL_BIT);
            if (st_reg == FHC_BOOT) begin
                base_reg <= BOOT_DEST;
                cnt_reg  <= 4'h0;
            end
        end
    end

    assign drv_op_go   = go_reg;
    assign drv_op_cmd  = boot_reg ? BOOT_CMD : s_cmd;
    assign drv_op_mask = boot_reg ? BOOT_DRV_MASK : s_mask;
    assign drv_op_buf  = boot_reg ? BOOT_DEST
                       : {sbuf_reg[6], sbuf_reg[5]};

    // ========================================================
    // drive controls, boot and interrupt
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wp_reg      <= 4'h0;
            restore_reg <= 4'h0;
            err_reg     <= 8'h00;
            boot_reg    <= 1'b0;
            intr_reg    <= 1'b0;
        end else begin
            restore_reg <= is_rest ? bc_low : 4'h0;
            if (is_wps) wp_reg <= wp_reg | bc_low;
            if (is_wpc) wp_reg <= wp_reg & ~bc_low;
            if (boot_req && st_reg == FHC_IDLE) boot_reg <= 1'b1;
            if (st_reg == FHC_BWAIT && drv_op_done) begin
                if (drv_op_stat == STAT_OK) boot_reg <= 1'b0;
                else err_reg <= drv_op_stat;
            end
            // completion set wins over a same-cycle clear
            if (intr_mode && st_reg == FHC_SWAIT && mem_ack)
                intr_reg <= 1'b1;
            else if (is_nop) intr_reg <= 1'b0;
        end
    end

    assign restore_req          = restore_reg;
    assign wr_protect           = wp_reg;
    assign error_code_indicator = err_reg;
    assign intr_pend            = intr_reg;

    // ========================================================
    // checks
    chk_load_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg == FHC_ADRLO && port_wr |=> st_reg == FHC_ADRHI)
        else $error("address byte decoded as command");
    chk_ptr_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg == FHC_ADRHI && port_wr
        |=> ptr_reg[$past(idx_reg)] == {$past(port_data), $past(lo_reg)})
        else $error("pointer not loaded");
    chk_ptr_stable: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(st_reg == FHC_ADRHI && port_wr) |=> $stable(ptr_reg[0]))
        else $error("pointer changed");
    chk_wp_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_wps |=> (wr_protect & $past(bc_low)) == $past(bc_low))
        else $error("protect not set");
    chk_wp_clr: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_wpc |=> (wr_protect & $past(bc_low)) == 4'h0)
        else $error("protect not cleared");
    chk_wp_reset: assert property (@(posedge core_clk)
        sys_rst |=> wr_protect == 4'h0)
        else $error("protect after reset");
    chk_restore_sel: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_rest |=> restore_req == $past(bc_low))
        else $error("restore mask wrong");
    chk_exec_fetch: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_exec && !boot_reg ##1 1 |=> mem_req && !mem_we
        && mem_addr == $past(base_reg))
        else $error("fetch not started");
    chk_stat_nz: assert property (@(posedge core_clk) disable iff (sys_rst)
        mem_we |-> mem_wdata != 8'h00)
        else $error("status zero on completion");
    chk_intr_clr: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_nop && !(st_reg == FHC_SWAIT) |=> !intr_pend)
        else $error("interrupt not cleared");
    cov_load: cover property (@(posedge core_clk) st_reg == FHC_ADRHI && port_wr);
    cov_exec: cover property (@(posedge core_clk) mem_we && mem_ack);
    cov_boot: cover property (@(posedge core_clk) st_reg == FHC_BWAIT && drv_op_done);
endmodule : fhc_interpreter

/* bench/fhc_host_model.sv */
// host memory and drive engine model for the command interpreter
`timescale 1ns/1ns
module fhc_host_model (
    input  wire logic        core_clk,
    input  wire logic        slow,
    input  wire logic [7:0]  op_stat,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic             mem_ack,
    output logic [7:0]       mem_rdata,
    input  wire logic        drv_op_go,
    output logic             drv_op_done,
    output logic [7:0]       drv_op_stat
);
    logic [7:0]  mem [0:65535];
    logic [15:0] rd_first;
    logic [15:0] wr_addr;
    logic [7:0]  wr_data;
    int          rd_cnt = 0;
    int          wr_cnt = 0;
    int          dly = 0;
    int          ocnt = 0;
    logic        was;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
        drv_op_done = 1'b0;
        drv_op_stat = 8'h00;
    end
    // =========================================================
    // dma answer and drive engine
    // data lines invert when idle so stale values never match
    always @(posedge core_clk) begin
        #1;
        was = mem_ack;
        mem_ack = 1'b0;
        drv_op_done = 1'b0;
        mem_rdata = ~mem_rdata;
        drv_op_stat = ~drv_op_stat;
        if (mem_req && !was) begin
            if (dly > 0) begin
                dly--;
            end else begin
                mem_ack = 1'b1;
                dly = slow ? 3 : 0;
                if (mem_we) begin
                    wr_addr = mem_addr;
                    wr_data = mem_wdata;
                    mem[mem_addr] = mem_wdata;
                    wr_cnt++;
                end else begin
                    if (rd_cnt == 0) rd_first = mem_addr;
                    mem_rdata = mem[mem_addr];
                    rd_cnt++;
                end
            end
        end
        if (drv_op_go) begin
            ocnt = slow ? 6 : 2;
        end else if (ocnt > 0) begin
            ocnt--;
            if (ocnt == 0) begin
                drv_op_done = 1'b1;
                drv_op_stat = op_stat;
            end
        end
    end
endmodule : fhc_host_model

/* bench/tb_fhc_interpreter.sv */
// self-checking bench for the host command interpreter
`timescale 1ns/1ns
module tb_fhc_interpreter;
    import fhc_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst, port_wr, boot_req, intr_mode, slow;
    logic [7:0] port_data, op_stat, mem_rdata, mem_wdata, drv_op_stat, eci;
    logic intr_pend, mem_req, mem_we, mem_ack, drv_op_go, drv_op_done;
    logic [15:0] mem_addr, drv_op_buf;
    logic [3:0] drv_op_cmd, drv_op_mask, restore_req, wr_protect;
    int error_cnt = 0;
    int check_count = 0;
    logic [31:0] lfsr_st = 32'h9F4A;
    int ptr [16];
    int wp = 0;
    logic [3:0]  go_cmd, go_mask;
    logic [15:0] go_buf;
    int          go_cnt = 0;
    always #50 core_clk = ~core_clk;
    // operation taken mid-cycle, where the engine inputs have settled
    always @(negedge core_clk) begin
        if (drv_op_go === 1'b1) begin
            go_cmd = drv_op_cmd;
            go_mask = drv_op_mask;
            go_buf = drv_op_buf;
            go_cnt++;
        end
    end
    fhc_interpreter uut (.core_clk(core_clk), .sys_rst(sys_rst),
        .port_wr(port_wr), .port_data(port_data), .boot_req(boot_req),
        .intr_mode(intr_mode), .intr_pend(intr_pend), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .drv_op_go(drv_op_go),
        .drv_op_cmd(drv_op_cmd), .drv_op_mask(drv_op_mask),
        .drv_op_buf(drv_op_buf), .drv_op_done(drv_op_done),
        .drv_op_stat(drv_op_stat), .restore_req(restore_req),
        .wr_protect(wr_protect), .error_code_indicator(eci));
    fhc_host_model host (.core_clk(core_clk), .slow(slow),
        .op_stat(op_stat), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .drv_op_go(drv_op_go),
        .drv_op_done(drv_op_done), .drv_op_stat(drv_op_stat));
    // =========================================================
    // helpers
    function automatic logic [7:0] rnd();
        lfsr_st = {lfsr_st[30:0], ^(lfsr_st & 32'h80200003)};
        return lfsr_st[7:0];
    endfunction : rnd
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one byte to the single host port, idle cycle after
    task automatic wr_byte(input logic [7:0] b);
        @(posedge core_clk);
        #1 port_wr = 1'b1;
        port_data = b;
        @(posedge core_clk);
        #1 port_wr = 1'b0;
        port_data = ~b;
    endtask : wr_byte
    task automatic run_str(input int k, input logic [7:0] c0, s0, rs, ex,
                           input int len);
        int p;
        int n;
        int g;
        logic [7:0] r;
        p = ptr[k];
        for (n = 0; n < 9; n++) begin
            r = rnd();
            host.mem[16'(p + n)] = r;
        end
        host.mem[16'(p)] = c0;
        host.mem[16'(p + 1)] = s0;
        host.rd_cnt = 0;
        host.wr_cnt = 0;
        op_stat = rs;
        g = go_cnt;
        wr_byte({BC_EXEC, 4'(k)});
        for (n = 0; n < 400 && host.wr_cnt == 0; n++) @(posedge core_clk);
        if (host.wr_cnt == 0) begin
            chk("status writes", 16'h1, 16'(host.wr_cnt));
            stop_test();
        end
        #2 chk("first fetch", 16'(p), host.rd_first);
        if (len > 0) chk("bytes read", 16'(len), 16'(host.rd_cnt));
        chk("status addr", 16'(p + 1), host.wr_addr);
        chk("status", {8'h00, ex}, {8'h00, host.wr_data});
        chk("ops", 16'(g + (ex[6] ? 0 : 1)), 16'(go_cnt));
        if (!ex[6]) begin
            chk("op cmd", {12'h0, c0[7:4]}, {12'h0, go_cmd});
            chk("op mask", {12'h0, c0[3:0]}, {12'h0, go_mask});
            r = host.mem[16'(p + 5)];
            if (len >= 7)
                chk("op buf", {host.mem[16'(p + 6)], r}, go_buf);
        end
        for (n = 0; n < 4 && intr_pend !== 1'b1; n++) @(posedge core_clk);
        #1 chk("intr set", 16'(intr_mode), {15'h0, intr_pend});
    endtask : run_str
    // =========================================================
    // main sequence
    logic [7:0] tc [9] = '{8'h21, 8'h32, 8'h44, 8'h88, 8'h98,
                           8'h21, 8'h23, 8'h20, 8'h61};
    logic [7:0] tr [9] = '{0, 0, 8'h05, 0, 0, 0, 0, 0, 0};
    logic [7:0] te [9] = '{8'h01, 8'h01, 8'h85, 8'h01, 8'h01,
                           8'hC1, 8'hC3, 8'hC2, 8'hC4};
    int tl [9] = '{7, 4, 5, 9, 6, 2, 2, 2, 2};
    initial begin
        int i;
        int k;
        int g;
        logic [7:0] r;
        logic [7:0] lo;
        logic [7:0] hi;
        port_wr = 1'b0;
        port_data = 8'h00;
        boot_req = 1'b0;
        intr_mode = 1'b1;
        slow = 1'b0;
        op_stat = 8'h00;
        sys_rst = 1'b1;
        for (i = 0; i < 16; i++) ptr[i] = (i == 0) ? 32'h80 : i * 4096;
        repeat (10) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        chk("protect at reset", 16'h0, {12'h0, wr_protect});
        for (i = 0; i < 16; i++) begin
            wr_byte({BC_RESTOR, 4'(i)});
            chk("restore", 16'(i), {12'h0, restore_req});
            @(posedge core_clk);
            #1 chk("restore end", 16'h0, {12'h0, restore_req});
            r = rnd();
            wr_byte({r[0] ? BC_WPSET : BC_WPCLR, r[7:4]});
            wp = r[0] ? (wp | r[7:4]) : (wp & ~int'(r[7:4]));
            chk("protect", 16'(wp), {12'h0, wr_protect});
        end
        $display("test drive commands done");
        run_str(0, 8'h21, 8'h00, 8'h00, 8'h01, 7);
        run_str(5, 8'h32, 8'h00, 8'h00, 8'h01, 4);
        wr_byte(8'h50);
        for (i = 0; i < 4; i++) begin
            r = rnd();
            k = r[3:0];
            lo = rnd();
            hi = rnd();
            if (i == 0) lo = 8'h31;
            wr_byte({BC_LOADP, 4'(k)});
            wr_byte(lo);
            wr_byte(hi);
            ptr[k] = {hi, lo};
            chk("protect kept", 16'(wp), {12'h0, wr_protect});
        end
        $display("test pointer loads done");
        for (i = 0; i < 9; i++) begin
            r = rnd();
            slow = i[0];
            run_str(r[3:0], tc[i], 8'(i == 5), tr[i], te[i], tl[i]);
            wr_byte({4'(5 + i), r[7:4]});
            chk("intr clear", 16'h0, {15'h0, intr_pend});
        end
        $display("test command strings done");
        // boot: first attempt fails, the retry succeeds
        lo = rnd() | 8'h80;
        op_stat = lo;
        g = go_cnt;
        @(posedge core_clk);
        #1 boot_req = 1'b1;
        @(posedge core_clk);
        #1 boot_req = 1'b0;
        for (i = 0; i < 50 && eci !== lo; i++) @(posedge core_clk);
        #1 op_stat = STAT_OK;
        chk("error code", {8'h00, lo}, {8'h00, eci});
        repeat (20) @(posedge core_clk);
        #1 chk("boot attempts", 16'(g + 2), 16'(go_cnt));
        chk("boot cmd", {12'h0, BOOT_CMD}, {12'h0, go_cmd});
        chk("boot drive", 16'h1, {12'h0, go_mask});
        chk("boot dest", 16'h0, go_buf);
        $display("test boot done");
        // mid-run reset: pointer defaults back, protects cleared
        wr_byte({BC_WPSET, 4'hF});
        @(posedge core_clk);
        #1 sys_rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        for (i = 0; i < 16; i++) ptr[i] = (i == 0) ? 32'h80 : i * 4096;
        chk("protect after reset", 16'h0, {12'h0, wr_protect});
        chk("error code at reset", 16'h0, {8'h00, eci});
        intr_mode = 1'b0;
        run_str(k, 8'h21, 8'h00, 8'h00, 8'h01, 7);
        $display("test mid-run reset done");
        stop_test();
    end
endmodule : tb_fhc_interpreter
